/* File: src/dles_pkg.sv */
/*
  Package for the link status and error flag block: register offsets,
  field positions, widths and reset values.
  Assumes a 32-bit register port with byte offsets as printed.
*/
package dles_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_TRIG = 8'hAC;
  localparam logic [7:0] OFF_PHYST = 8'hB0;
  localparam logic [7:0] OFF_SPARE_A = 8'hB4;
  localparam logic [7:0] OFF_SPARE_B = 8'hB8;
  localparam logic [7:0] OFF_ST0 = 8'hBC;
  localparam logic [7:0] OFF_ST1 = 8'hC0;
  localparam logic [7:0] OFF_MSK0 = 8'hC4;
  localparam logic [7:0] OFF_MSK1 = 8'hC8;
  localparam int TRIG_W = 4;
  localparam int PHYST_W = 13;
  localparam int ST0_W = 21;
  localparam int ST1_W = 13;
  localparam int ACK_LSB = 0;
  localparam int PHYERR_LSB = 16;
  localparam int ST1_HS_TO = 0;
  localparam int ST1_LP_TO = 1;
  localparam int ST1_ECC1 = 2;
  localparam int ST1_ECCM = 3;
  localparam int ST1_CRC = 4;
  localparam int ST1_SIZE = 5;
  localparam int ST1_EOTP = 6;
  localparam int ST1_PIX_OVF = 7;
  localparam int ST1_CMD_OVF = 8;
  localparam int ST1_PWR_OVF = 9;
  localparam int ST1_SEND_UDF = 10;
  localparam int ST1_RD_UDF = 11;
  localparam int ST1_RCV_OVF = 12;
  localparam logic [3:0] TRIG_RST = 4'h0;
  localparam logic [20:0] ST0_RST = 21'h000000;
  localparam logic [12:0] ST1_RST = 13'h0000;
  localparam logic [20:0] MSK0_RST = 21'h000000;
  localparam logic [12:0] MSK1_RST = 13'h0000;
  localparam logic [12:0] PHYST_RST = 13'h0000;
  localparam logic SPARE_RST = 1'b0;
endpackage : dles_pkg

/* File: src/dles_top.sv */
/*
  Status, error flag and interrupt mask bank of a display serial link
  host: mirrors lane status, holds trigger requests, collects flags.
  Assumes all event inputs are one-cycle pulses or levels synchronous
  to ref_clk; reads and writes are single-cycle strobes.
*/
`timescale 1ns/1ns
module dles_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [dles_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic [dles_pkg::TRIG_W-1:0] link_trigger_req,
  input wire logic phy_lock,
  input wire logic phy_direction,
  input wire logic clk_lane_stopped_flag,
  input wire logic clk_lane_not_sleeping_flag,
  input wire logic lane0_stopped_flag,
  input wire logic lane0_not_sleeping_flag,
  input wire logic lane0_sleep_escape_received,
  input wire logic lane1_stopped_flag,
  input wire logic lane1_not_sleeping_flag,
  input wire logic lane2_stopped_flag,
  input wire logic lane2_not_sleeping_flag,
  input wire logic lane3_stopped_flag,
  input wire logic lane3_not_sleeping_flag,
  input wire logic escape_entry_fault_signal,
  input wire logic escape_sync_fault_signal,
  input wire logic control_fault_signal,
  input wire logic low_level_contention_signal,
  input wire logic high_level_contention_signal,
  input wire logic ack_report_valid,
  input wire logic [15:0] ack_report,
  input wire logic cmd_fifo_full,
  input wire logic cmd_write,
  input wire logic pld_w_fifo_full,
  input wire logic pld_write,
  input wire logic pld_w_fifo_empty,
  input wire logic pkt_build_active,
  input wire logic pld_r_fifo_empty,
  input wire logic rd_data_pass_active,
  input wire logic pld_r_fifo_full,
  input wire logic readback_rx_active,
  input wire logic pix_fifo_full,
  input wire logic pix_line_store_active,
  input wire logic eotp_missing,
  input wire logic pkt_size_fault,
  input wire logic crc_fault,
  input wire logic ecc_single_fault,
  input wire logic ecc_multi_fault,
  input wire logic lowpower_rx_timeout_flag,
  input wire logic highspeed_tx_timeout_flag,
  output logic cmd_fifo_push,
  output logic pld_w_fifo_push,
  output logic irq
);
  import dles_pkg::*;

  logic [TRIG_W-1:0] trig_r;
  logic [PHYST_W-1:0] physt_r;
  logic [PHYST_W-1:0] physt_nxt;
  logic [ST0_W-1:0] st0_r;
  logic [ST0_W-1:0] st0_set;
  logic [ST1_W-1:0] st1_r;
  logic [ST1_W-1:0] st1_set;
  logic [ST0_W-1:0] msk0_r;
  logic [ST1_W-1:0] msk1_r;
  logic spare_a_r;
  logic spare_b_r;
  logic [31:0] rdata_nxt;
  logic rd_st0;
  logic rd_st1;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  assign rd_st0 = reg_rd && hit(reg_addr, OFF_ST0);
  assign rd_st1 = reg_rd && hit(reg_addr, OFF_ST1);

  // writable control registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      trig_r <= TRIG_RST;
      msk0_r <= MSK0_RST;
      msk1_r <= MSK1_RST;
      spare_a_r <= SPARE_RST;
      spare_b_r <= SPARE_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, OFF_TRIG)) trig_r <= reg_wdata[TRIG_W-1:0];
      if (hit(reg_addr, OFF_MSK0)) msk0_r <= reg_wdata[ST0_W-1:0];
      if (hit(reg_addr, OFF_MSK1)) msk1_r <= reg_wdata[ST1_W-1:0];
      if (hit(reg_addr, OFF_SPARE_A)) spare_a_r <= reg_wdata[0];
      if (hit(reg_addr, OFF_SPARE_B)) spare_b_r <= reg_wdata[0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) link_trigger_req <= TRIG_RST;
    else if (reg_wr && hit(reg_addr, OFF_TRIG))
      link_trigger_req <= reg_wdata[TRIG_W-1:0];
  end

  // lane status mirror, one register stage
  always_comb begin
    physt_nxt = '0;
    physt_nxt[0] = phy_lock;
    physt_nxt[1] = phy_direction;
    physt_nxt[2] = clk_lane_stopped_flag;
    physt_nxt[3] = clk_lane_not_sleeping_flag;
    physt_nxt[4] = lane0_stopped_flag;
    physt_nxt[5] = lane0_not_sleeping_flag;
    physt_nxt[6] = lane0_sleep_escape_received;
    physt_nxt[7] = lane1_stopped_flag;
    physt_nxt[8] = lane1_not_sleeping_flag;
    physt_nxt[9] = lane2_stopped_flag;
    physt_nxt[10] = lane2_not_sleeping_flag;
    physt_nxt[11] = lane3_stopped_flag;
    physt_nxt[12] = lane3_not_sleeping_flag;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) physt_r <= PHYST_RST;
    else physt_r <= physt_nxt;
  end

  // event sources
  always_comb begin
    st0_set = '0;
    if (ack_report_valid)
      st0_set[ACK_LSB +: 16] = ack_report;
    st0_set[PHYERR_LSB + 0] = escape_entry_fault_signal;
    st0_set[PHYERR_LSB + 1] = escape_sync_fault_signal;
    st0_set[PHYERR_LSB + 2] = control_fault_signal;
    st0_set[PHYERR_LSB + 3] = low_level_contention_signal;
    st0_set[PHYERR_LSB + 4] = high_level_contention_signal;
  end

  always_comb begin
    st1_set = '0;
    st1_set[ST1_HS_TO] = highspeed_tx_timeout_flag;
    st1_set[ST1_LP_TO] = lowpower_rx_timeout_flag;
    st1_set[ST1_ECC1] = ecc_single_fault;
    st1_set[ST1_ECCM] = ecc_multi_fault;
    st1_set[ST1_CRC] = crc_fault;
    st1_set[ST1_SIZE] = pkt_size_fault;
    st1_set[ST1_EOTP] = eotp_missing;
    st1_set[ST1_PIX_OVF] = pix_line_store_active && pix_fifo_full;
    st1_set[ST1_CMD_OVF] = cmd_write && cmd_fifo_full;
    st1_set[ST1_PWR_OVF] = pld_write && pld_w_fifo_full;
    st1_set[ST1_SEND_UDF] = pkt_build_active && pld_w_fifo_empty;
    st1_set[ST1_RD_UDF] = rd_data_pass_active && pld_r_fifo_empty;
    st1_set[ST1_RCV_OVF] = readback_rx_active && pld_r_fifo_full;
  end

  // push only when there is room, so a full FIFO drops the write
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cmd_fifo_push <= 1'b0;
      pld_w_fifo_push <= 1'b0;
    end else begin
      cmd_fifo_push <= cmd_write && !cmd_fifo_full;
      pld_w_fifo_push <= pld_write && !pld_w_fifo_full;
    end
  end

  // sticky flags: clear on read, a new event in the same cycle wins
  always_ff @(posedge ref_clk) begin
    if (!rstn) st0_r <= ST0_RST;
    else if (rd_st0) st0_r <= st0_set;
    else st0_r <= st0_r | st0_set;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) st1_r <= ST1_RST;
    else if (rd_st1) st1_r <= st1_set;
    else st1_r <= st1_r | st1_set;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) irq <= 1'b0;
    else irq <= |(st0_r & msk0_r) || |(st1_r & msk1_r);
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    case (reg_addr)
      OFF_TRIG: rdata_nxt[TRIG_W-1:0] = trig_r;
      OFF_PHYST: rdata_nxt[PHYST_W-1:0] = physt_r;
      OFF_SPARE_A: rdata_nxt[0] = spare_a_r;
      OFF_SPARE_B: rdata_nxt[0] = spare_b_r;
      OFF_ST0: rdata_nxt[ST0_W-1:0] = st0_r;
      OFF_ST1: rdata_nxt[ST1_W-1:0] = st1_r;
      OFF_MSK0: rdata_nxt[ST0_W-1:0] = msk0_r;
      OFF_MSK1: rdata_nxt[ST1_W-1:0] = msk1_r;
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) reg_rdata <= 32'h00000000;
    else if (reg_rd) reg_rdata <= rdata_nxt;
  end

  // assertions
  property p_trig_write;
    @(posedge ref_clk) disable iff (!rstn)
      reg_wr && reg_addr == OFF_TRIG
        |=> link_trigger_req == $past(reg_wdata[3:0]);
  endproperty
  a_trig_write: assert property (p_trig_write)
    else $error("trigger not loaded");

  property p_lock_mirror;
    @(posedge ref_clk) disable iff (!rstn)
      ##1 physt_r[0] == $past(phy_lock);
  endproperty
  a_lock_mirror: assert property (p_lock_mirror)
    else $error("lock mismatch");

  property p_dir_read;
    @(posedge ref_clk) disable iff (!rstn)
      reg_rd && reg_addr == OFF_PHYST |=> reg_rdata[1] == $past(physt_r[1]);
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction bad");

  property p_cmd_ovf;
    @(posedge ref_clk) disable iff (!rstn)
      cmd_write && cmd_fifo_full |=> st1_r[8] && !cmd_fifo_push;
  endproperty
  a_cmd_ovf: assert property (p_cmd_ovf)
    else $error("cmd overflow missed");

  property p_pld_ovf;
    @(posedge ref_clk) disable iff (!rstn)
      pld_write && pld_w_fifo_full |=> st1_r[9] && !pld_w_fifo_push;
  endproperty
  a_pld_ovf: assert property (p_pld_ovf)
    else $error("payload overflow");

  property p_esc_err;
    @(posedge ref_clk) disable iff (!rstn)
      escape_entry_fault_signal |=> st0_r[16];
  endproperty
  a_esc_err: assert property (p_esc_err)
    else $error("escape error lost");

  property p_hold;
    @(posedge ref_clk) disable iff (!rstn)
      st1_r[4] && !rd_st1 |=> st1_r[4];
  endproperty
  a_hold: assert property (p_hold)
    else $error("flag dropped early");

  property p_clear;
    @(posedge ref_clk) disable iff (!rstn)
      rd_st0 && !st0_set[0] |=> !st0_r[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag not cleared");

  property p_irq;
    @(posedge ref_clk) disable iff (!rstn)
      (st1_r[0] && msk1_r[0]) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq missing");

  property p_irq_masked;
    @(posedge ref_clk) disable iff (!rstn)
      (st0_r & msk0_r) == '0 && (st1_r & msk1_r) == '0 |=> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("irq spurious");

  property p_lane_mirror;
    @(posedge ref_clk) disable iff (!rstn)
      ##1 physt_r[2] == $past(clk_lane_stopped_flag)
        && physt_r[12] == $past(lane3_not_sleeping_flag);
  endproperty
  a_lane_mirror: assert property (p_lane_mirror)
    else $error("lane state mismatch");

  property p_esc_mirror;
    @(posedge ref_clk) disable iff (!rstn)
      ##1 physt_r[6] == $past(lane0_sleep_escape_received);
  endproperty
  a_esc_mirror: assert property (p_esc_mirror)
    else $error("escape state mismatch");

  property p_ack_copy;
    @(posedge ref_clk) disable iff (!rstn)
      ack_report_valid |=> (st0_r[15:0] & $past(ack_report)) == $past(ack_report);
  endproperty
  a_ack_copy: assert property (p_ack_copy)
    else $error("ack report lost");

  property p_send_udf;
    @(posedge ref_clk) disable iff (!rstn)
      pkt_build_active && pld_w_fifo_empty |=> st1_r[ST1_SEND_UDF];
  endproperty
  a_send_udf: assert property (p_send_udf)
    else $error("send underflow missed");

  property p_rd_udf;
    @(posedge ref_clk) disable iff (!rstn)
      rd_data_pass_active && pld_r_fifo_empty |=> st1_r[ST1_RD_UDF];
  endproperty
  a_rd_udf: assert property (p_rd_udf)
    else $error("read underflow missed");

  property p_rcv_ovf;
    @(posedge ref_clk) disable iff (!rstn)
      readback_rx_active && pld_r_fifo_full |=> st1_r[ST1_RCV_OVF];
  endproperty
  a_rcv_ovf: assert property (p_rcv_ovf)
    else $error("receive overflow missed");

  property p_pix_ovf;
    @(posedge ref_clk) disable iff (!rstn)
      pix_line_store_active && pix_fifo_full |=> st1_r[ST1_PIX_OVF];
  endproperty
  a_pix_ovf: assert property (p_pix_ovf)
    else $error("pixel overflow missed");

  property p_eotp;
    @(posedge ref_clk) disable iff (!rstn)
      eotp_missing |=> st1_r[ST1_EOTP];
  endproperty
  a_eotp: assert property (p_eotp)
    else $error("missing eotp not flagged");

  property p_crc;
    @(posedge ref_clk) disable iff (!rstn)
      crc_fault |=> st1_r[ST1_CRC];
  endproperty
  a_crc: assert property (p_crc)
    else $error("crc fault not flagged");

  property p_ecc;
    @(posedge ref_clk) disable iff (!rstn)
      ecc_multi_fault |=> st1_r[ST1_ECCM];
  endproperty
  a_ecc: assert property (p_ecc)
    else $error("ecc fault not flagged");

  property p_lp_to;
    @(posedge ref_clk) disable iff (!rstn)
      lowpower_rx_timeout_flag |=> st1_r[ST1_LP_TO];
  endproperty
  a_lp_to: assert property (p_lp_to)
    else $error("low-power timeout not flagged");

  c_ovf: cover property (@(posedge ref_clk) cmd_write && cmd_fifo_full);
  c_irq: cover property (@(posedge ref_clk) $rose(irq));
  c_clr: cover property (@(posedge ref_clk) rd_st1 && st1_r != '0);
  c_race: cover property (@(posedge ref_clk) rd_st0 && st0_set != '0);
endmodule : dles_top

/* File: tb/dles_phy_model.sv */
/*
  Lane-side model of the transceiver: presents lock, direction, lane
  state levels and lane 0 fault pulses in status register bit order.
  Assumes the bench drives lvl and err just after rising edges.
*/
`timescale 1ns/1ns
module dles_phy_model (
  input wire logic ref_clk,
  input wire logic [12:0] lvl,
  input wire logic [4:0] err,
  output logic [12:0] st,
  output logic [4:0] flt
);
  // levels change and faults pulse one edge after the bench asks
  always_ff @(posedge ref_clk) begin
    st <= lvl;
    flt <= err;
  end
endmodule : dles_phy_model

/* File: tb/dles_top_tb.sv */
/*
  Self-checking bench for the link status and error flag bank.
  Assumes dles_pkg, dles_top and dles_phy_model are compiled first.
*/
`timescale 1ns/1ns
module dles_top_tb;
  import dles_pkg::*;
  localparam logic [31:0] ONES_RD [9] = '{32'hF, 32'h0, 32'h1, 32'h1,
    32'h0, 32'h0, 32'h1FFFFF, 32'h1FFF, 32'h0};
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] rv;
  logic [3:0] trig;
  logic [12:0] lvl = 13'h0;
  logic [12:0] st;
  logic [4:0] err = 5'h0;
  logic [4:0] flt;
  logic [12:0] ea = 13'h0;
  logic [12:0] eb = 13'h0;
  logic ack_v = 1'b0;
  logic [15:0] ack = 16'h0;
  logic cmd_push;
  logic pld_push;
  logic irq;
  int num_errors = 0;
  int samples_checked = 0;

  dles_phy_model phy_u (.ref_clk(ref_clk), .lvl(lvl), .err(err),
    .st(st), .flt(flt));

  dles_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .link_trigger_req(trig), .phy_lock(st[0]),
    .phy_direction(st[1]), .clk_lane_stopped_flag(st[2]),
    .clk_lane_not_sleeping_flag(st[3]), .lane0_stopped_flag(st[4]),
    .lane0_not_sleeping_flag(st[5]), .lane0_sleep_escape_received(st[6]),
    .lane1_stopped_flag(st[7]), .lane1_not_sleeping_flag(st[8]),
    .lane2_stopped_flag(st[9]), .lane2_not_sleeping_flag(st[10]),
    .lane3_stopped_flag(st[11]), .lane3_not_sleeping_flag(st[12]),
    .escape_entry_fault_signal(flt[0]), .escape_sync_fault_signal(flt[1]),
    .control_fault_signal(flt[2]), .low_level_contention_signal(flt[3]),
    .high_level_contention_signal(flt[4]), .ack_report_valid(ack_v),
    .ack_report(ack), .cmd_fifo_full(ea[8]), .cmd_write(eb[8]),
    .pld_w_fifo_full(ea[9]), .pld_write(eb[9]),
    .pld_w_fifo_empty(ea[10]), .pkt_build_active(eb[10]),
    .pld_r_fifo_empty(ea[11]), .rd_data_pass_active(eb[11]),
    .pld_r_fifo_full(ea[12]), .readback_rx_active(eb[12]),
    .pix_fifo_full(ea[7]), .pix_line_store_active(eb[7]),
    .eotp_missing(ea[6] & eb[6]), .pkt_size_fault(ea[5] & eb[5]),
    .crc_fault(ea[4] & eb[4]), .ecc_single_fault(ea[2] & eb[2]),
    .ecc_multi_fault(ea[3] & eb[3]),
    .lowpower_rx_timeout_flag(ea[1] & eb[1]),
    .highspeed_tx_timeout_flag(ea[0] & eb[0]),
    .cmd_fifo_push(cmd_push), .pld_w_fifo_push(pld_push), .irq(irq));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd

  // one-cycle event: full/empty halves on a, activity halves on b
  task automatic pulse(input logic [12:0] a, input logic [12:0] b);
    @(posedge ref_clk);
    ea <= a;
    eb <= b;
    @(posedge ref_clk);
    ea <= 13'h0;
    eb <= 13'h0;
    #1;
    chk({30'h0, pld_push, cmd_push}, {30'h0, b[9:8] & ~a[9:8]});
  endtask : pulse

  task automatic fault(input int i);
    @(posedge ref_clk);
    err <= 5'h1 << i;
    @(posedge ref_clk);
    err <= 5'h0;
  endtask : fault

  task automatic t_regs();
    for (int i = 0; i < 9; i++) begin
      rd(8'(8'hAC + 4 * i));
      chk(rv, 32'h0);
      wr(8'(8'hAC + 4 * i), 32'hFFFFFFFF);
      rd(8'(8'hAC + 4 * i));
      chk(rv, ONES_RD[i]);
    end
    chk({28'h0, trig}, 32'hF);
    wr(OFF_TRIG, 32'hA5);
    settle(1);
    chk({28'h0, trig}, 32'h5);
  endtask : t_regs

  task automatic t_phy();
    for (int i = 0; i < 13; i++) begin
      @(posedge ref_clk);
      lvl <= 13'h1 << i;
      repeat (2) @(posedge ref_clk);
      rd(OFF_PHYST);
      chk(rv, 32'h1 << i);
    end
    lvl <= 13'h0;
  endtask : t_phy

  task automatic t_st0();
    for (int i = 0; i < 5; i++) begin
      fault(i);
      settle(2);
      rd(OFF_ST0);
      chk(rv, 32'h10000 << i);
    end
    @(posedge ref_clk);
    ack <= 16'hFFFF;
    @(posedge ref_clk);
    ack <= 16'hA5C3;
    ack_v <= 1'b1;
    @(posedge ref_clk);
    ack_v <= 1'b0;
    ack <= 16'h0;
    rd(OFF_ST0);
    chk(rv, 32'hA5C3);
    rd(OFF_ST0);
    chk(rv, 32'h0);
    @(posedge ref_clk);
    reg_addr <= OFF_ST0;
    reg_rd <= 1'b1;
    ack <= 16'h0001;
    ack_v <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    ack_v <= 1'b0;
    ack <= 16'h0;
    #1;
    chk(reg_rdata, 32'h0);
    rd(OFF_ST0);
    chk(rv, 32'h1);
  endtask : t_st0

  task automatic t_st1();
    for (int i = 0; i < 13; i++) begin
      pulse(13'h1 << i, 13'h1 << i);
      rd(OFF_ST1);
      chk(rv, 32'h1 << i);
    end
    pulse(13'h1FFF, 13'h0);
    pulse(13'h0, 13'h1FFF);
    rd(OFF_ST1);
    chk(rv, 32'h0);
    pulse(13'h1FFF, 13'h1FFF);
    rd(OFF_ST1);
    chk(rv, 32'h1FFF);
  endtask : t_st1

  task automatic t_irq();
    wr(OFF_MSK0, 32'h0);
    wr(OFF_MSK1, 32'h0);
    pulse(13'h10, 13'h10);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_MSK1, 32'h10);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    rd(OFF_ST1);
    chk(rv, 32'h10);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_MSK0, 32'h1);
    fault(4);
    settle(3);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_MSK0, 32'h100000);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    rd(OFF_ST0);
    chk(rv, 32'h100000);
    settle(2);
    chk({31'h0, irq}, 32'h0);
  endtask : t_irq

  task automatic t_rst();
    pulse(13'h10, 13'h10);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    chk({27'h0, irq, trig}, 32'h0);
    rd(OFF_ST1);
    chk(rv, 32'h0);
    rd(OFF_MSK1);
    chk(rv, 32'h0);
  endtask : t_rst

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs();
    t_phy();
    t_st0();
    t_st1();
    t_irq();
    t_rst();
    finish_test();
  end
endmodule : dles_top_tb
